// ==== src/clk_standby_ctrl.sv ====
// System clock and standby control registers behind an AXI4-Lite slave
// Assumes area write strobes are synchronous one-cycle pulses on clk_sys_i
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module clk_standby_ctrl #(
    parameter int           WU_CNT_W = 16,
    parameter logic [7:0]   KEY_ONE  = 8'h5a,
    parameter logic [7:0]   KEY_TWO  = 8'ha5
) (
    input  wire logic                        clk_sys_i,
    input  wire logic                        reset_i,
    input  wire logic [clk_standby_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [31:0]                 s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [clk_standby_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [31:0]                      s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    input  wire logic [2:0]                  area_write_i,
    output clk_standby_pkg::clk_ctrl_t       ctrl_o,
    output logic                             warmup_busy_o,
    output logic                             protect_o,
    output logic                             irq_o
);
    import clk_standby_pkg::*;

    logic [7:0] clk_a_reg;
    logic [7:0] clk_b_reg;
    logic [7:0] clk_c_reg;
    logic [7:0] extmem_reg;
    logic [2:0] area_en_reg;
    logic [2:0] area_flag_reg;
    logic       key_armed_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_have_reg;
    logic        w_have_reg;
    logic        wr_fire;
    logic        wr_hit;
    logic [7:0]  wr_idx;
    logic [7:0]  wbyte;
    logic        wb0;
    logic        wu_busy;
    logic        wu_done;
    logic [2:0]  area_set;
    logic [IRQ_W-1:0] irq_event;

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Aligned word index inside the register range
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) &&
               (a[ADDR_W-1:2] >= {2'h0, IDX_CLK_A}) &&
               (a[ADDR_W-1:2] <= {2'h0, IDX_IRQ_MASK});
    endfunction

    // Write channel: address and data taken in either order
    assign s_axi_awready_o = !aw_have_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_have_reg && !s_axi_bvalid_o;
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
    assign wr_idx  = awaddr_reg[ADDR_W-3:2];
    assign wr_hit  = wr_fire && addr_ok(awaddr_reg);
    assign wbyte   = wdata_reg[7:0];
    assign wb0     = wr_hit && wstrb_reg[0];

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            aw_have_reg    <= 1'b0;
            w_have_reg     <= 1'b0;
            awaddr_reg     <= '0;
            wdata_reg      <= '0;
            wstrb_reg      <= '0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_i;
                wstrb_reg  <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            clk_a_reg <= CLK_A_RST;
        end else if (wb0 && wr_idx == IDX_CLK_A) begin
            clk_a_reg <= wbyte & CLK_A_WMASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            clk_b_reg <= CLK_B_RST;
        end else if (wb0 && wr_idx == IDX_CLK_B) begin
            clk_b_reg <= wbyte & CLK_B_WMASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            clk_c_reg <= CLK_C_RST;
        end else if (wb0 && wr_idx == IDX_CLK_C) begin
            clk_c_reg <= wbyte & CLK_C_WMASK;
        end
    end

    // external memory control; protect bit kept apart
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            extmem_reg <= EXTMEM_RST;
        end else if (wb0 && wr_idx == IDX_EXTMEM_A) begin
            extmem_reg <= wbyte & EXTMEM_WMASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            key_armed_reg <= 1'b0;
            protect_o     <= 1'b0;
        end else if (wb0 && wr_idx == IDX_KEY_1) begin
            key_armed_reg <= (wbyte == KEY_ONE);
        end else if (wb0 && wr_idx == IDX_KEY_2) begin
            key_armed_reg <= 1'b0;
            if (key_armed_reg && wbyte == KEY_TWO) begin
                protect_o <= !protect_o;
            end
        end else if (wb0) begin
            key_armed_reg <= 1'b0;
        end
    end

    // Pins run 1A, 2B-2C, 2A; register bits run the other way
    assign area_set = {area_write_i[0], area_write_i[1], area_write_i[2]}
                      & area_en_reg;

    // enables; flags, set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            area_en_reg   <= AREA_RST[2:0];
            area_flag_reg <= AREA_RST[2:0];
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (area_set[i]) begin
                    area_flag_reg[i] <= 1'b1;
                end else if (wb0 && wr_idx == IDX_AREA && !wbyte[i]) begin
                    area_flag_reg[i] <= 1'b0;
                end
            end
            if (wb0 && wr_idx == IDX_AREA) begin
                area_en_reg <= wbyte[6:4];
            end
        end
    end

    // warm-up start on a written one
    warmup_timer #(
        .CNT_W      (WU_CNT_W)
    ) u_warmup (
        .clk_sys_i  (clk_sys_i),
        .reset_i    (reset_i),
        .start_i    (wb0 && wr_idx == IDX_CLK_A && wbyte[WARMUP_BIT]),
        .len_sel_i  (clk_c_reg[5:4]),
        .busy_o     (wu_busy),
        .done_o     (wu_done)
    );
    assign warmup_busy_o = wu_busy;

    // Status bit 0 warm-up end, bits 1..3 areas 1A, 2B-2C, 2A
    assign irq_event = {area_set[0], area_set[1], area_set[2], wu_done};

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (irq_event[i]) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wb0 && wr_idx == IDX_IRQ_STAT && wbyte[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
            if (wb0 && wr_idx == IDX_IRQ_MASK) begin
                irq_mask_reg <= wbyte[IRQ_W-1:0];
            end
        end
    end
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // Decoded controls
    always_comb begin
        ctrl_o.hf_osc_enable           = clk_a_reg[7];
        ctrl_o.lf_osc_enable           = clk_a_reg[6];
        ctrl_o.hf_osc_after_stop       = clk_a_reg[5];
        ctrl_o.lf_osc_after_stop       = clk_a_reg[4];
        ctrl_o.clock_after_stop_select = clk_a_reg[3];
        ctrl_o.prescaler_src           = clk_a_reg[1:0];
        ctrl_o.prescaler_reserved      = (clk_a_reg[1:0] != PRE_GEAR) &&
                                         (clk_a_reg[1:0] != PRE_DIV16);
        ctrl_o.system_clock_source     = clk_b_reg[3];
        ctrl_o.gear                    = clk_b_reg[2:0];
        ctrl_o.gear_reserved           = clk_b_reg[2:0] > GEAR_MAX;
        ctrl_o.power_save_disable      = clk_c_reg[7];
        ctrl_o.standby_select          = standby_mode_t'(clk_c_reg[3:2]);
        ctrl_o.drive_in_idle_one       = clk_c_reg[0] && !clk_c_reg[1];
        ctrl_o.drive_in_stop           = clk_c_reg[0] && clk_c_reg[1];
        ctrl_o.display_src_clock_sel   = extmem_reg[6];
        ctrl_o.address_keep            = extmem_reg[5];
        ctrl_o.melody_src_clock_sel    = extmem_reg[4];
        ctrl_o.external_hf_clock       = extmem_reg[2];
        ctrl_o.hf_osc_drive_strength   = extmem_reg[1];
        ctrl_o.lf_osc_drive_strength   = extmem_reg[0];
    end

    // Read channel, one cycle latency, data held until rready
    assign s_axi_arready_o = !s_axi_rvalid_o;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= addr_ok(s_axi_araddr_i) ? RESP_OKAY
                                                       : RESP_SLVERR;
            case (s_axi_araddr_i[ADDR_W-1:2])
                IDX_CLK_A:    s_axi_rdata_o <= {24'h0, clk_a_reg[7:3],
                                                wu_busy, clk_a_reg[1:0]};
                IDX_CLK_B:    s_axi_rdata_o <= {24'h0, clk_b_reg};
                IDX_CLK_C:    s_axi_rdata_o <= {24'h0, clk_c_reg};
                IDX_EXTMEM_A: s_axi_rdata_o <= {24'h0, protect_o,
                                                extmem_reg[6:0]};
                IDX_AREA:     s_axi_rdata_o <= {25'h0, area_en_reg, 1'b0,
                                                area_flag_reg};
                IDX_IRQ_STAT: s_axi_rdata_o <= {28'h0, irq_stat_reg};
                IDX_IRQ_MASK: s_axi_rdata_o <= {28'h0, irq_mask_reg};
                default:      s_axi_rdata_o <= '0;
            endcase
            if (!addr_ok(s_axi_araddr_i)) begin
                s_axi_rdata_o <= '0;
            end
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // flag 0 never falls while its area is written and enabled
    chk_flag_set_wins: assert property (
        area_set[0] |=> area_flag_reg[0])
        else $error("area flag lost");
    chk_flag_needs_en: assert property (
        !area_flag_reg[1] && !area_set[1] |=> !area_flag_reg[1])
        else $error("flag set without enable");
    chk_flag_holds: assert property (
        area_flag_reg[2] && !(wb0 && wr_idx == IDX_AREA && !wbyte[2])
        |=> area_flag_reg[2])
        else $error("area flag dropped");
    // warm-up starts on write of one
    chk_warmup_start: assert property (
        wb0 && wr_idx == IDX_CLK_A && wbyte[WARMUP_BIT] |=> wu_busy)
        else $error("warm-up did not start");
    chk_warmup_len: assert property (
        $rose(wu_busy) && clk_c_reg[5:4] == WU_SHORT
        |-> ##255 wu_busy ##1 !wu_busy)
        else $error("short warm-up length wrong");
    // protect only moves on second key
    chk_protect_keys: assert property (
        !(wb0 && wr_idx == IDX_KEY_2) |=> $stable(protect_o))
        else $error("protect moved without key");
    chk_gear_write: assert property (
        wb0 && wr_idx == IDX_CLK_B |=> ctrl_o.gear == $past(wbyte[2:0]))
        else $error("gear not written");
    // bit 3 of ext memory register stays 0
    chk_ext_bit3_zero: assert property (
        extmem_reg[3] == 1'b0)
        else $error("reserved bit set");
    chk_drive_excl: assert property (
        !(ctrl_o.drive_in_idle_one && ctrl_o.drive_in_stop))
        else $error("drive modes overlap");
    // Irq level follows masked status
    chk_irq_level: assert property (
        irq_o == |(irq_stat_reg & irq_mask_reg))
        else $error("irq mismatch");
    // Write answer one edge after both halves held
    chk_write_resp: assert property (
        wr_fire |=> s_axi_bvalid_o)
        else $error("write response missing");
    // Read answer one edge after address taken
    chk_read_resp: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response missing");

    cov_warmup_done: cover property (wu_done);
    cov_flag_set:    cover property ($rose(area_flag_reg[2]));
    cov_protect_on:  cover property ($rose(protect_o));
    cov_irq_raised:  cover property ($rose(irq_o));
    cov_slave_error: cover property (
        s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule
`default_nettype wire

// ==== src/clk_standby_pkg.sv ====
// Constants and types for the system clock and standby control block
// Assumes a 32-bit AXI4-Lite master and one 25 MHz system clock
package clk_standby_pkg;
    // Printed offsets are not multiples of four: index, byte address = 4*index
    localparam logic [7:0] IDX_CLK_A    = 8'he0;
    localparam logic [7:0] IDX_CLK_B    = 8'he1;
    localparam logic [7:0] IDX_CLK_C    = 8'he2;
    localparam logic [7:0] IDX_EXTMEM_A = 8'he3;
    localparam logic [7:0] IDX_KEY_1    = 8'he4;
    localparam logic [7:0] IDX_KEY_2    = 8'he5;
    localparam logic [7:0] IDX_AREA     = 8'he6;
    localparam logic [7:0] IDX_IRQ_STAT = 8'he7;
    localparam logic [7:0] IDX_IRQ_MASK = 8'he8;
    localparam int         ADDR_W       = 12;

    localparam logic [7:0] CLK_A_RST    = 8'he0;
    localparam logic [7:0] CLK_A_WMASK  = 8'hfb;
    localparam int         WARMUP_BIT   = 2;
    localparam logic [7:0] CLK_B_RST    = 8'h04;
    localparam logic [7:0] CLK_B_WMASK  = 8'h0f;
    localparam logic [7:0] CLK_C_RST    = 8'h2c;
    localparam logic [7:0] CLK_C_WMASK  = 8'hbf;
    localparam logic [7:0] EXTMEM_RST   = 8'h03;
    localparam logic [7:0] EXTMEM_WMASK = 8'h77;
    localparam int         PROTECT_BIT  = 7;
    localparam logic [7:0] AREA_RST     = 8'h00;

    localparam logic [1:0] PRE_GEAR     = 2'h0;
    localparam logic [1:0] PRE_DIV16    = 2'h2;
    localparam logic [2:0] GEAR_MAX     = 3'h4;
    localparam logic [1:0] WU_SHORT     = 2'h1;
    localparam logic [1:0] WU_MID       = 2'h2;
    localparam int         WU_EXP_SHORT = 8;
    localparam int         WU_EXP_MID   = 14;
    localparam int         WU_EXP_LONG  = 16;

    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // Irq status bits: warm-up end, three area writes
    localparam int         IRQ_W        = 4;

    typedef enum logic [1:0] {
        SB_RESERVED,
        SB_STOP,
        SB_IDLE_ONE,
        SB_IDLE_TWO
    } standby_mode_t;

    typedef struct packed {
        logic          hf_osc_enable;
        logic          lf_osc_enable;
        logic          hf_osc_after_stop;
        logic          lf_osc_after_stop;
        logic          clock_after_stop_select;
        logic          system_clock_source;
        logic [2:0]    gear;
        logic [1:0]    prescaler_src;
        logic          power_save_disable;
        standby_mode_t standby_select;
        logic          drive_in_idle_one;
        logic          drive_in_stop;
        logic          display_src_clock_sel;
        logic          melody_src_clock_sel;
        logic          address_keep;
        logic          external_hf_clock;
        logic          hf_osc_drive_strength;
        logic          lf_osc_drive_strength;
        logic          gear_reserved;
        logic          prescaler_reserved;
    } clk_ctrl_t;
endpackage

// ==== src/warmup_timer.sv ====
// Warm-up counter: runs 2^exp input clock periods once started
// Assumes the input clock period is counted on the system clock
`timescale 1ns/1ns
`default_nettype none
module warmup_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    input  wire logic             start_i,
    input  wire logic [1:0]       len_sel_i,
    output logic                  busy_o,
    output logic                  done_o
);
    import clk_standby_pkg::*;

    logic [CNT_W:0] count_reg;
    logic [CNT_W:0] target;

    if (CNT_W < WU_EXP_LONG) begin : g_cnt_w_check
        $error("warmup_timer: CNT_W too small");
    end

    always_comb begin
        case (len_sel_i)
            WU_SHORT: target = (CNT_W+1)'(1) << WU_EXP_SHORT;
            WU_MID:   target = (CNT_W+1)'(1) << WU_EXP_MID;
            default:  target = (CNT_W+1)'(1) << WU_EXP_LONG;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            count_reg <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_o    <= 1'b1;
                count_reg <= (CNT_W+1)'(1);
            end else if (busy_o) begin
                if (count_reg >= target) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + (CNT_W+1)'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/clk_standby_ctrl_test.sv ====
// Self-checking bench for the clock and standby control block
// Assumes the block alone, AXI4-Lite with bready and rready held high
`timescale 1ns/1ns
`default_nettype none
module clk_standby_ctrl_test;
    import clk_standby_pkg::*;
    localparam logic [7:0] K1 = 8'h5a;
    localparam logic [7:0] K2 = 8'ha5;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wd = '0;
    logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
    logic [2:0]  area = '0;
    logic        aw_r, w_r, b_v, ar_r, r_v, busy, prot, irq;
    logic [1:0]  b_rs, r_rs;
    logic [31:0] rd;
    clk_ctrl_t   ctrl;
    int          err_total = 0;
    int          n_tests = 0;
    logic [31:0] seed = 32'hbe0a;
    logic [7:0]  m [0:8];
    logic [7:0]  last_d;
    int          last_i;
    logic        wb;

    clk_standby_ctrl #(.WU_CNT_W(16), .KEY_ONE(K1), .KEY_TWO(K2)) dut_u (
        .clk_sys_i(clk), .reset_i(rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(aw_v),
        .s_axi_awready_o(aw_r), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r),
        .s_axi_bresp_o(b_rs), .s_axi_bvalid_o(b_v), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(ar_v),
        .s_axi_arready_o(ar_r), .s_axi_rdata_o(rd), .s_axi_rresp_o(r_rs),
        .s_axi_rvalid_o(r_v), .s_axi_rready_i(1'b1), .area_write_i(area),
        .ctrl_o(ctrl), .warmup_busy_o(busy), .protect_o(prot), .irq_o(irq));

    initial forever #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ah, wh, an, wn, bn;
        ah = 0; wh = 0; bn = 0;
        awaddr <= a; wd <= d; aw_v <= 1'b1; w_v <= 1'b1;
        while (!(ah && wh)) begin
            @(negedge clk);
            an = aw_v & aw_r; wn = w_v & w_r;
            @(posedge clk);
            if (an) begin aw_v <= 1'b0; ah = 1; end
            if (wn) begin w_v <= 1'b0; wh = 1; end
        end
        while (!bn) begin
            @(negedge clk); bn = b_v; r = b_rs; @(posedge clk);
        end
    endtask

    task automatic rdt(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic an, rn;
        an = 0; rn = 0;
        araddr <= a; ar_v <= 1'b1;
        while (!an) begin @(negedge clk); an = ar_r; @(posedge clk); end
        ar_v <= 1'b0;
        while (!rn) begin
            @(negedge clk); rn = r_v; d = rd; r = r_rs; @(posedge clk);
        end
    endtask

    task automatic rw(input int i, input logic [7:0] d);
        logic [1:0] r;
        wr(12'((i + 224) * 4), {24'h0, d}, r);
        chk("bresp", RESP_OKAY, r);
        case (i)
            0: m[0] = d & 8'hfb;
            1: m[1] = d & 8'h0f;
            2: m[2] = d & 8'hbf;
            3: m[3] = (m[3] & 8'h80) | (d & 8'h77);
            5: if (last_i == 4 && last_d == K1 && d == K2) m[3][7] = ~m[3][7];
            6: m[6] = {1'b0, d[6:4], 1'b0, m[6][2:0] & d[2:0]};
            7: m[7] = m[7] & ~d;
            8: m[8] = d & 8'h0f;
            default: ;
        endcase
        last_i = i; last_d = d;
    endtask

    task automatic rc(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        rdt(12'((i + 224) * 4), d, r);
        chk("rresp", RESP_OKAY, r);
        chk("rdata", {24'h0, m[i] | ((i == 0 && wb) ? 8'h04 : 8'h00)}, d);
        chk("irq", |(m[7] & m[8]), irq);
    endtask

    task automatic ck();
        chk("ctrl", {m[0][7:3], m[1][3:0], m[0][1:0], m[2][7], m[2][3:2],
            m[2][0] & ~m[2][1], m[2][0] & m[2][1], m[3][6:4], m[3][2:0],
            m[1][2:0] > 3'h4, m[0][0]},
            {ctrl.hf_osc_enable, ctrl.lf_osc_enable, ctrl.hf_osc_after_stop,
            ctrl.lf_osc_after_stop, ctrl.clock_after_stop_select,
            ctrl.system_clock_source, ctrl.gear, ctrl.prescaler_src,
            ctrl.power_save_disable, ctrl.standby_select,
            ctrl.drive_in_idle_one, ctrl.drive_in_stop,
            ctrl.display_src_clock_sel, ctrl.address_keep,
            ctrl.melody_src_clock_sel, ctrl.external_hf_clock,
            ctrl.hf_osc_drive_strength, ctrl.lf_osc_drive_strength,
            ctrl.gear_reserved, ctrl.prescaler_reserved});
    endtask

    initial begin
        #400000;
        err_total++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [7:0]  v;
        logic [2:0]  p;
        logic [1:0]  r;
        int          i, n;
        m[0] = CLK_A_RST; m[1] = CLK_B_RST; m[2] = CLK_C_RST;
        m[3] = EXTMEM_RST; m[4] = 0; m[5] = 0; m[6] = AREA_RST;
        m[7] = 0; m[8] = 0; wb = 0; last_i = 0; last_d = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 9; i++) if (i != 4 && i != 5) rc(i);
        ck();
        chk("protect", 1'b0, prot);
        $display("done reset values");
        for (n = 0; n < 40; n++) begin
            i = int'(rnd() % 4);
            v = 8'(rnd());
            if (i == 0) v[2] = 1'b0;
            // Bit 3 of the memory control register always written 0
            if (i == 3) v[3] = 1'b0;
            rw(i, v);
            rc(i);
            ck();
        end
        $display("done random fields");
        rw(2, (m[2] & 8'hcf) | 8'h10);
        rw(0, m[0] | 8'h04);
        wb = 1;
        rc(0);
        n = 0;
        while (busy === 1'b1 && n < 2000) begin @(negedge clk); n++; end
        @(posedge clk);
        chk("warmup_len", 1, n >= 246 && n <= 256);
        wb = 0; m[7][0] = 1'b1;
        rc(0);
        rc(7);
        rw(7, 8'h01);
        $display("done warm-up");
        // Keys written first then second
        rw(4, K1); rw(5, K2);
        rc(3); chk("protect", m[3][7], prot);
        rw(5, K2); rc(3); chk("protect", m[3][7], prot);
        rw(4, K1); rw(5, K1); rc(3); chk("protect", m[3][7], prot);
        rw(4, K1); rw(5, K2); rc(3); chk("protect", m[3][7], prot);
        $display("done protection");
        for (n = 0; n < 12; n++) begin
            d = rnd();
            rw(8, d[11:8]);
            rw(6, {1'b0, d[6:4], 4'h7});
            p = d[14:12];
            area <= p;
            @(posedge clk);
            area <= 3'h0;
            @(posedge clk);
            m[6][2:0] = m[6][2:0] | ({p[0], p[1], p[2]} & m[6][6:4]);
            m[7][3:1] = m[7][3:1] | (p & {m[6][4], m[6][5], m[6][6]});
            rc(6);
            rc(7);
            if (d[15]) rw(6, {1'b0, d[6:4], 1'b0, d[18:16]});
            if (d[15]) rw(7, d[23:20]);
            rc(6);
            rc(7);
        end
        $display("done area flags");
        wr(12'h3a4, 32'h0000_00ff, r);
        chk("bresp", RESP_SLVERR, r);
        rdt(12'h3a4, d, r);
        chk("rresp", RESP_SLVERR, r);
        chk("rdata", 32'h0, d);
        rdt(12'h381, d, r);
        chk("rresp", RESP_SLVERR, r);
        chk("rdata", 32'h0, d);
        for (i = 0; i < 4; i++) rc(i);
        $display("done bus errors");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        m[0] = CLK_A_RST; m[1] = CLK_B_RST; m[2] = CLK_C_RST;
        m[3] = EXTMEM_RST; m[6] = AREA_RST; m[7] = 0; m[8] = 0;
        last_i = 0; last_d = 0;
        for (i = 0; i < 9; i++) if (i != 4 && i != 5) rc(i);
        ck();
        chk("protect", 1'b0, prot);
        $display("done second reset");
        end_of_test();
    end
endmodule
`default_nettype wire
